// >>> shared/sbi_map.svh
// register indices, field positions, reset values and timing counts
// of the two-wire serial bus interface; definitions only
`ifndef SBI_MAP_SVH
`define SBI_MAP_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define IDX_CR1 10'h240
`define IDX_DBR 10'h241
`define IDX_OAR 10'h242
`define IDX_CR2 10'h243
`define IDX_BR0 10'h244
`define IDX_BR1 10'h245
`define IDX_NONE 10'h3FF

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CR1_BC 7:5
`define CR1_ACK 4
`define CR1_SCK 2:0
`define CR2_MST 7
`define CR2_TRX 6
`define CR2_BB 5
`define CR2_PIN 4
`define CR2_MODE 3:2
`define CR2_SWR 1:0
`define BR0_RUN 6
`define BR1_EN 7

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define MODE_I2C 2'h2
`define SWR_ARM 2'h2
`define SWR_FIRE 2'h1
`define SOFT_RESET_MONITOR_RST 1'b1
`define SCK_RST 3'h0

// ----------------------------------------------------------------
// timing: half scl period at the fastest rate select
// ----------------------------------------------------------------
`define CLK_NS 25
`define HALF_NS 200
`define HALF_CYC ((`HALF_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// >>> shared/sbi_pkg.sv
// types shared by the bus slave and the serial bus interface core
// assumes nothing beyond a SystemVerilog compiler
package sbi_pkg;

   // ----------------------------------------------------------------
   // master clock generator states
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      M_IDLE = 5'b00001,
      M_START = 5'b00010,
      M_LOW = 5'b00100,
      M_HIGH = 5'b01000,
      M_STOP = 5'b10000
   } mstate_e;

   // ----------------------------------------------------------------
   // register access from the bus slave
   // ----------------------------------------------------------------
   typedef struct packed {
      logic wr;
      logic [9:0] widx;
      logic [7:0] wdata;
      logic rd;
      logic [9:0] ridx;
   } bus_req_s;

   // ----------------------------------------------------------------
   // open-drain pin drive
   // ----------------------------------------------------------------
   typedef struct packed {
      logic scl_out;
      logic scl_oe;
      logic sda_out;
      logic sda_oe;
   } pin_s;

endpackage : sbi_pkg

// >>> hdl/sbi_ahb_slave.sv
// ahb-lite slave front end for the byte-wide registers
// assumes one slave, single word transfers, read data given combinationally
`timescale 1ns/1ps
`include "sbi_map.svh"
module sbi_ahb_slave import sbi_pkg::*; (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // register side
   output bus_req_s req,
   input wire logic [7:0] rdata
);

   typedef struct packed {
      logic rdy;
      logic [31:0] rd;
      logic wr_pend;
      logic [9:0] widx;
   } ahb_s;

   ahb_s q;
   ahb_s n;
   logic take;
   logic [9:0] aidx;

   // ----------------------------------------------------------------
   // address phase decode
   // ----------------------------------------------------------------
   always_comb begin
      take = hsel & hready & htrans[1];
      if (haddr[31:12] == 20'h0_0000 && haddr[1:0] == 2'h0) begin
         aidx = haddr[11:2];
      end else begin
         aidx = `IDX_NONE;
      end
      req.wr = q.wr_pend;
      req.widx = q.widx;
      req.wdata = hwdata[7:0];
      req.rd = take & ~hwrite;
      req.ridx = aidx;
      n = q;
      n.rdy = 1'b1;
      n.wr_pend = take & hwrite;
      if (take) begin
         n.widx = aidx;
      end
      if (take && !hwrite) begin
         n.rd = {24'h00_0000, rdata};
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '{rdy: 1'b1, default: '0};
      end else begin
         q <= n;
      end
   end

   assign hreadyout = q.rdy;
   assign hrdata = q.rd;
   assign hresp = 1'b0;

endmodule : sbi_ahb_slave

// >>> hdl/sbi_i2c_top.sv
// two-wire serial bus interface core: master and slave, both directions
// assumes open-drain pads resolved outside and an ahb-lite master
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "sbi_map.svh"
module sbi_i2c_top import sbi_pkg::*; (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // two-wire link
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // standby and interrupt
   input wire logic idle2_standby,
   output logic bus_iface_irq
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [3:0] word_bits(logic [2:0] bc, logic first);
      word_bits = (first || bc == 3'h0) ? 4'h8 : {1'b0, bc};
   endfunction : word_bits

   function automatic logic [10:0] half_cycles(logic [2:0] sck);
      half_cycles = 11'(`HALF_CYC << sck);
   endfunction : half_cycles

   // true means pull sda low for bit slot i
   function automatic logic drv(logic [3:0] i, logic [3:0] nb, logic [7:0] sh,
                                logic transmit_select, logic ack_ok);
      if (i < nb) begin
         drv = transmit_select & ~sh[7];
      end else begin
         drv = ~transmit_select & ack_ok;
      end
   endfunction : drv

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic scl_s1, scl_s2, scl_p;
      logic sda_s1, sda_s2, sda_p;
      logic [2:0] bc;
      logic ack;
      logic [2:0] sck;
      logic soft_reset_monitor;
      logic master_select, transmit_select, bb, pin;
      logic [1:0] mode;
      logic swr_arm, swr_go;
      logic al, aas, ad0, lrb;
      logic [6:0] sa;
      logic address_recognition_off;
      logic idle2_run, rate_en;
      logic [7:0] sh;
      logic [7:0] rxbuf;
      logic [3:0] cnt;
      logic seen_rise, first, active, done, stop_req, hi_seen;
      mstate_e mstate;
      logic [10:0] tcnt;
      logic irq;
      pin_s pins;
   } st_s;

   localparam st_s ST_RST = '{
      scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1,
      sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1,
      soft_reset_monitor: `SOFT_RESET_MONITOR_RST, sck: `SCK_RST,
      pin: 1'b1, mstate: M_IDLE, default: '0};

   st_s q;
   st_s n;
   bus_req_s req;
   logic [7:0] rdata;
   logic run, rise, fall, start, stop;
   logic [3:0] nb;
   logic [3:0] total;
   logic [10:0] hc;
   logic match, ack_ok, release_pin;
   logic [7:0] wd;

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   sbi_ahb_slave u_ahb (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .hresp(hresp),
      .req(req),
      .rdata(rdata)
   );

   // ----------------------------------------------------------------
   // register read mux
   // ----------------------------------------------------------------
   always_comb begin
      if (req.ridx == `IDX_CR1) begin
         rdata = {3'h0, q.ack, 3'h0, q.soft_reset_monitor};
      end else if (req.ridx == `IDX_DBR) begin
         rdata = q.rxbuf;
      end else if (req.ridx == `IDX_CR2) begin
         rdata = {q.master_select, q.transmit_select, q.bb, q.pin, q.al, q.aas, q.ad0, q.lrb};
      end else if (req.ridx == `IDX_BR0) begin
         rdata = {1'b0, q.idle2_run, 6'h00};
      end else begin
         rdata = 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      wd = req.wdata;
      run = q.rate_en & ~(idle2_standby & ~q.idle2_run) & (q.mode == `MODE_I2C);
      rise = run & ~q.scl_p & q.scl_s2;
      fall = run & q.scl_p & ~q.scl_s2;
      start = run & q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
      stop = run & q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
      nb = word_bits(q.bc, q.first);
      total = nb + {3'h0, q.ack};
      hc = half_cycles(q.sck);
      match = (q.sh[7:1] == q.sa) || (q.sh[7:1] == 7'h00);
      ack_ok = ~(q.first & ~q.master_select & ~q.address_recognition_off) | match;
      release_pin = 1'b0;
      n = q;
      n.irq = 1'b0;
      n.swr_go = 1'b0;
      if (q.swr_go) begin
         n = ST_RST;
         n.mode = q.mode;
      end

      // bus monitor
      if (start) begin
         n.bb = 1'b1;
         n.cnt = 4'h0;
         n.seen_rise = 1'b0;
         n.first = 1'b1;
         n.aas = 1'b0;
         n.ad0 = 1'b0;
         n.done = 1'b0;
         n.active = 1'b1;
         if (!q.master_select) begin
            n.transmit_select = 1'b0;
         end
      end
      if (stop) begin
         n.bb = 1'b0;
         n.transmit_select = 1'b0;
         n.active = 1'b0;
         n.aas = 1'b0;
         n.ad0 = 1'b0;
         n.done = 1'b0;
      end

      // bit engine, paced by the observed scl edges
      if (rise && q.active && !q.done) begin
         n.seen_rise = 1'b1;
         if (q.cnt < nb) begin
            n.sh = {q.sh[6:0], q.sda_s2};
            if (q.master_select && q.transmit_select && !q.pins.sda_oe && !q.sda_s2) begin
               n.al = 1'b1;
               n.master_select = 1'b0;
               n.transmit_select = 1'b0;
               n.pins.sda_oe = 1'b0;
               n.pins.scl_oe = 1'b0;
               n.mstate = M_IDLE;
            end
         end else begin
            n.lrb = q.sda_s2;
         end
      end
      if (fall && q.active && !q.done) begin
         if (!q.seen_rise) begin
            n.pins.sda_oe = drv(q.cnt, nb, q.sh, q.transmit_select, ack_ok);
         end else if (q.cnt + 4'h1 == total) begin
            n.seen_rise = 1'b0;
            n.done = 1'b1;
            n.cnt = 4'h0;
            n.pin = q.pin & q.first & ~q.master_select & ~q.address_recognition_off & ~match;
            n.irq = ~(q.first & ~q.master_select & ~q.address_recognition_off & ~match);
            n.sh = 8'h00;
            n.rxbuf = q.sh;
            n.first = 1'b0;
            n.pins.sda_oe = 1'b0;
            if (q.first && !q.master_select && !q.address_recognition_off) begin
               if (match) begin
                  n.aas = 1'b1;
                  n.ad0 = (q.sh[7:1] == 7'h00);
                  n.transmit_select = q.sh[0];
               end else begin
                  n.active = 1'b0;
               end
            end
            if (q.first && q.master_select && !q.lrb) begin
               n.transmit_select = ~q.sh[0];
            end
         end else begin
            n.seen_rise = 1'b0;
            n.cnt = q.cnt + 4'h1;
            n.pins.sda_oe = drv(q.cnt + 4'h1, nb, q.sh, q.transmit_select, ack_ok);
         end
      end

      // register writes and read side effects
      if (req.wr) begin
         if (req.widx == `IDX_CR1) begin
            n.bc = wd[`CR1_BC];
            n.ack = wd[`CR1_ACK];
            n.sck = wd[`CR1_SCK];
         end else if (req.widx == `IDX_DBR) begin
            n.sh = wd;
            release_pin = 1'b1;
         end else if (req.widx == `IDX_OAR) begin
            n.sa = wd[7:1];
            n.address_recognition_off = wd[0];
         end else if (req.widx == `IDX_CR2) begin
            n.al = n.al & ~q.al;
            n.mode = wd[`CR2_MODE];
            if (!q.bb && wd[7:4] == 4'hF) begin
               n.master_select = 1'b1;
               n.transmit_select = 1'b1;
               n.pin = 1'b1;
               n.mstate = M_START;
               n.tcnt = 11'h000;
            end else if (q.bb && wd[7:4] == 4'hD) begin
               n.stop_req = 1'b1;
               n.active = 1'b0;
               n.pin = 1'b1;
            end else begin
               n.master_select = wd[`CR2_MST];
               n.transmit_select = wd[`CR2_TRX];
               release_pin = wd[`CR2_PIN];
            end
            if (wd[`CR2_SWR] == `SWR_FIRE && q.swr_arm) begin
               n.swr_go = 1'b1;
               n.soft_reset_monitor = 1'b0;
            end
            n.swr_arm = (wd[`CR2_SWR] == `SWR_ARM);
         end else if (req.widx == `IDX_BR0) begin
            n.idle2_run = wd[`BR0_RUN];
         end else if (req.widx == `IDX_BR1) begin
            n.rate_en = wd[`BR1_EN];
         end
      end
      if (req.rd && req.ridx == `IDX_DBR) begin
         release_pin = 1'b1;
      end
      if (release_pin) begin
         n.pin = 1'b1;
         if (n.done && !n.stop_req) begin
            n.done = 1'b0;
            n.pins.sda_oe = drv(4'h0, nb, n.sh, n.transmit_select, 1'b1);
         end
      end

      // master clock generator
      if (run) begin
         n.tcnt = (q.tcnt == 11'h7FF) ? q.tcnt : q.tcnt + 11'h001;
         case (q.mstate)
            M_START: begin
               n.pins.sda_oe = 1'b1;
               if (q.tcnt >= hc) begin
                  n.mstate = M_LOW;
                  n.pins.scl_oe = 1'b1;
                  n.tcnt = 11'h000;
               end
            end
            M_LOW: begin
               n.pins.scl_oe = 1'b1;
               if (q.tcnt >= hc && q.stop_req) begin
                  n.pins.sda_oe = 1'b1;
                  n.mstate = M_STOP;
                  n.tcnt = 11'h000;
               end else if (q.tcnt >= hc && q.pin && !q.done) begin
                  n.mstate = M_HIGH;
                  n.pins.scl_oe = 1'b0;
                  n.hi_seen = 1'b0;
                  n.tcnt = 11'h000;
               end
            end
            M_HIGH: begin
               if (!q.scl_s2) begin
                  n.tcnt = 11'h000;
                  if (q.hi_seen) begin
                     n.mstate = M_LOW;
                     n.pins.scl_oe = 1'b1;
                  end
               end else begin
                  n.hi_seen = 1'b1;
                  if (q.tcnt >= hc) begin
                     n.mstate = M_LOW;
                     n.pins.scl_oe = 1'b1;
                     n.tcnt = 11'h000;
                  end
               end
            end
            M_STOP: begin
               n.pins.sda_oe = 1'b1;
               if (q.pins.scl_oe) begin
                  if (q.tcnt >= hc) begin
                     n.pins.scl_oe = 1'b0;
                     n.tcnt = 11'h000;
                  end
               end else if (!q.scl_s2) begin
                  n.tcnt = 11'h000;
               end else if (q.tcnt >= hc) begin
                  n.pins.sda_oe = 1'b0;
                  n.stop_req = 1'b0;
                  n.mstate = M_IDLE;
               end
            end
            default: begin
               n.mstate = M_IDLE;
            end
         endcase
      end

      // slave holds scl low while service is pending
      if (!n.master_select) begin
         n.pins.scl_oe = n.done & ~n.pin & n.active;
      end
      if (n.mode != `MODE_I2C) begin
         n.pins.scl_oe = 1'b0;
         n.pins.sda_oe = 1'b0;
      end
      n.pins.scl_out = 1'b0;
      n.pins.sda_out = 1'b0;

      // pin synchronisers
      n.scl_s1 = scl_in;
      n.scl_s2 = q.scl_s1;
      n.scl_p = q.scl_s2;
      n.sda_s1 = sda_in;
      n.sda_s2 = q.sda_s1;
      n.sda_p = q.sda_s2;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= ST_RST;
      end else begin
         q <= n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign scl_out = q.pins.scl_out;
   assign scl_oe = q.pins.scl_oe;
   assign sda_out = q.pins.sda_out;
   assign sda_oe = q.pins.sda_oe;
   assign bus_iface_irq = q.irq;

endmodule : sbi_i2c_top

// >>> bench/sbi_i2c_props.sv
// concurrent checks on the ports of the serial bus interface top
// assumes a single hclk domain; bound to every sbi_i2c_top instance
`timescale 1ns/1ps
module sbi_i2c_props (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // two-wire link
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe,
   // interrupt
   input wire logic bus_iface_irq
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_held_low;
      scl_oe [*2];
   endsequence
   property p_pins_low;
      scl_out == 1'b0 && sda_out == 1'b0;
   endproperty
   property p_irq_pulse;
      bus_iface_irq |=> !bus_iface_irq;
   endproperty
   property p_irq_scl_low;
      bus_iface_irq |-> !scl_in;
   endproperty
   property p_hold_after_irq;
      bus_iface_irq |=> s_held_low;
   endproperty
   property p_high_min;
      $fell(scl_oe) |=> !scl_oe [*7];
   endproperty
   property p_low_min;
      $rose(scl_oe) |=> scl_oe [*7];
   endproperty
   property p_no_irq_reset;
      $rose(hresetn) |-> !bus_iface_irq [*4];
   endproperty
   property p_quiet_reset;
      $rose(hresetn) |-> !scl_oe && !sda_oe;
   endproperty

   a_pins_low: assert property (p_pins_low)
      else $error("pin driven high");
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("irq longer than one cycle");
   a_irq_scl_low: assert property (p_irq_scl_low)
      else $error("irq while scl high");
   a_hold_after_irq: assert property (p_hold_after_irq)
      else $error("scl not held after irq");
   a_high_min: assert property (p_high_min)
      else $error("scl high too short");
   a_low_min: assert property (p_low_min)
      else $error("scl low too short");
   a_no_irq_reset: assert property (p_no_irq_reset)
      else $error("irq right after reset");
   a_quiet_reset: assert property (p_quiet_reset)
      else $error("line pulled at reset");
endmodule : sbi_i2c_props

bind sbi_i2c_top sbi_i2c_props u_props (.hclk(hclk), .hresetn(hresetn), .scl_in(scl_in),
   .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
   .bus_iface_irq(bus_iface_irq));

// >>> bench/i2c_far_end.sv
// behavioural far end of the two-wire bus: addressed slave and simple master
// assumes resolved line levels at its inputs; oe high pulls a line low
`timescale 1ns/1ps
module i2c_far_end #(
   parameter logic [6:0] own_addr = 7'h2A,
   parameter int half_ns = 100
) (
   // resolved bus levels
   input wire logic scl,
   input wire logic sda,
   // pull-low enables
   output logic scl_oe,
   output logic sda_oe,
   // observation
   output logic [7:0] got,
   output logic [7:0] clocks,
   output logic [7:0] starts
);
   logic m_scl;
   logic m_sda;
   logic s_sda;
   logic [7:0] sh;
   int cnt;

   assign scl_oe = m_scl;
   assign sda_oe = m_sda | s_sda;
   initial begin
      m_scl = 1'b0;
      m_sda = 1'b0;
      s_sda = 1'b0;
      cnt = 15;
      sh = 8'h00;
      got = 8'h00;
      clocks = 8'h00;
      starts = 8'h00;
   end
   // start and stop detection
   always @(negedge sda) if (scl) begin
      cnt = 0;
      clocks = 8'h00;
      starts = starts + 8'h01;
   end
   always @(posedge sda) if (scl) cnt = 15;
   // bits enter msb first at each rise
   always @(posedge scl) if (cnt < 9) begin
      sh = {sh[6:0], sda};
      cnt = cnt + 1;
      clocks = clocks + 8'h01;
   end
   // own address acknowledged during the ninth clock
   always @(negedge scl) if (cnt == 8) begin
      got = sh;
      s_sda = (sh[7:1] == own_addr);
   end else if (cnt == 9) begin
      s_sda = 1'b0;
      cnt = 15;
   end

   task automatic send_byte(input logic [7:0] b, output logic ack);
      m_sda = 1'b1;
      #(half_ns);
      m_scl = 1'b1;
      for (int i = 7; i >= -1; i--) begin
         m_sda = (i >= 0) ? !b[i] : 1'b0;
         #(half_ns);
         m_scl = 1'b0;
         wait (scl === 1'b1);
         ack = !sda;
         #(half_ns);
         m_scl = 1'b1;
      end
   endtask : send_byte

   task automatic send_stop();
      m_sda = 1'b1;
      #(half_ns);
      m_scl = 1'b0;
      wait (scl === 1'b1);
      #(half_ns);
      m_sda = 1'b0;
   endtask : send_stop
endmodule : i2c_far_end

// >>> bench/test_serial_bus_iface_i2c.sv
// self-checking bench for the serial bus interface top
// assumes the behavioural far end on the bus and a zero-wait ahb slave
`timescale 1ns/1ps
`include "sbi_map.svh"
module test_serial_bus_iface_i2c;
   logic hclk, hresetn, hwrite, idle2_standby, ack;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata;
   wire logic hready, hresp, scl_oe, sda_oe, p_scl_oe, p_sda_oe, irq;
   wire logic [31:0] hrdata;
   wire logic [7:0] got, clocks, starts;
   wire logic scl = !(scl_oe | p_scl_oe);
   wire logic sda = !(sda_oe | p_sda_oe);
   int bad_count, n_tests;

   sbi_i2c_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .scl_in(scl), .scl_out(),
      .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe),
      .idle2_standby(idle2_standby), .bus_iface_irq(irq));
   i2c_far_end u_far (.scl(scl), .sda(sda), .scl_oe(p_scl_oe), .sda_oe(p_sda_oe),
      .got(got), .clocks(clocks), .starts(starts));

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] v, input logic [7:0] exp);
      n_tests++;
      if (v !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, v, exp);
      end
   endtask : check

   task automatic ahb(input logic w, input logic [9:0] idx, input logic [7:0] wd,
      output logic [7:0] rv);
      @(posedge hclk);
      haddr <= {20'h0_0000, idx, 2'b00};
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, wd};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rv = hrdata[7:0];
   endtask : ahb

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [7:0] x;
      ahb(1'b1, idx, d, x);
   endtask : wr

   task automatic rd(input logic [9:0] idx, output logic [7:0] v);
      ahb(1'b0, idx, 8'h00, v);
   endtask : rd

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 5000) begin
         @(posedge hclk);
         n++;
      end
      check(8'(n < 5000), 8'h01);
      repeat (8) @(posedge hclk);
   endtask : wait_irq

   task automatic wait_free();
      logic [7:0] v;
      int n;
      n = 0;
      v = 8'hFF;
      while (v[5] !== 1'b0 && n < 40) begin
         rd(`IDX_CR2, v);
         n++;
      end
      check(v & 8'h60, 8'h00);
   endtask : wait_free

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_values();
      logic [7:0] v;
      rd(`IDX_CR1, v);
      check(v, 8'h01);
      rd(`IDX_OAR, v);
      check(v, 8'h00);
      rd(`IDX_NONE, v);
      check(v, 8'h00);
      check(8'(hresp), 8'h00);
      rd(`IDX_CR2, v);
      check(v & 8'h20, 8'h00);
   endtask : t_reset_values

   task automatic t_master_write();
      logic [7:0] v;
      wr(`IDX_BR1, 8'h80);
      wr(`IDX_CR1, 8'h10);
      wr(`IDX_DBR, 8'h54);
      wr(`IDX_CR2, 8'hF8);
      wait_irq();
      check(got, 8'h54);
      check(clocks, 8'h09);
      rd(`IDX_CR2, v);
      check(v & 8'hFC, 8'hE0);
      wr(`IDX_CR2, 8'hD8);
      wait_free();
   endtask : t_master_write

   task automatic t_idle2_ack_off();
      logic [7:0] s0;
      s0 = starts;
      idle2_standby <= 1'b1;
      wr(`IDX_BR0, 8'h00);
      wr(`IDX_CR1, 8'h20);
      wr(`IDX_DBR, 8'hA0);
      wr(`IDX_CR2, 8'hF8);
      repeat (200) @(posedge hclk);
      check(starts, s0);
      wr(`IDX_BR0, 8'h40);
      wait_irq();
      check(got, 8'hA0);
      check(clocks, 8'h08);
      wr(`IDX_CR2, 8'hD8);
      wait_free();
      idle2_standby <= 1'b0;
   endtask : t_idle2_ack_off

   task automatic t_slave(input logic [7:0] a, input logic [7:0] st);
      logic [7:0] v;
      wr(`IDX_CR1, 8'h10);
      wr(`IDX_OAR, 8'h6A);
      wr(`IDX_CR2, 8'h18);
      u_far.send_byte(a, ack);
      check(8'(ack), 8'h01);
      wait_irq();
      rd(`IDX_CR2, v);
      check(v & 8'hE4, st);
      if (a[0]) wr(`IDX_DBR, 8'hFF);
      else rd(`IDX_DBR, v);
      if (!a[0]) check(v, 8'h6A);
      u_far.send_stop();
      wait_free();
   endtask : t_slave

   task automatic t_soft_reset();
      logic [7:0] v;
      wr(`IDX_CR1, 8'h10);
      wr(`IDX_CR2, 8'h1A);
      wr(`IDX_CR2, 8'h19);
      rd(`IDX_CR1, v);
      check(v, 8'h01);
      rd(`IDX_CR2, v);
      check(v, 8'h10);
   endtask : t_soft_reset

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   initial begin
      #200_000;
      bad_count++;
      end_sim();
   end

   initial begin
      bad_count = 0;
      n_tests = 0;
      hresetn = 1'b0;
      haddr = 32'h0000_0000;
      hwdata = 32'h0000_0000;
      htrans = 2'b00;
      hwrite = 1'b0;
      idle2_standby = 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset_values();
      t_master_write();
      t_idle2_ack_off();
      t_slave(8'h6A, 8'h24);
      t_slave(8'h6B, 8'h64);
      t_soft_reset();
      end_sim();
   end
endmodule : test_serial_bus_iface_i2c
